// ==== mcc_control_regs.sv ====
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module mcc_control_regs (
  input  wire logic                    core_clk,
  input  wire logic                    resetn,
  input  wire logic                    ce,
  input  wire logic [3:0]              regAddr,
  input  wire logic [31:0]             regWdata,
  input  wire logic                    regWr,
  input  wire logic                    regRd,
  output logic      [31:0]             regRdata,
  input  wire logic                    softReset,
  input  wire logic                    warmTempPin,
  input  wire logic                    overTempPin,
  input  wire logic [4:0]              clkRatioPins,
  input  wire logic                    transferErrN,
  input  wire logic                    machineCheckN,
  input  wire mcc_pkg::mcc_err_s       err,
  input  wire logic                    machineCheckVectorEnable,
  input  wire logic                    bkptInvert,
  input  wire logic                    opValid,
  input  wire mcc_pkg::mcc_op_e        opKind,
  output mcc_pkg::mcc_ctl_s            ctl,
  output logic                         strobePin,
  output logic      [mcc_pkg::COLS-1:0] colDisable,
  output logic      [mcc_pkg::COLS-1:0] colDiscard,
  output logic                         mcTrap,
  output logic                         checkstop,
  output logic                         bcastValid,
  output mcc_pkg::mcc_op_e             bcastKind,
  output logic                         localDone
);
  mcc_pkg::mcc_state_s st;
  mcc_pkg::mcc_state_s nxt;
  logic                    wrTrap;
  logic                    wrCb;
  logic                    wrCol;
  logic                    colWrOk;
  logic                    softRise;
  logic                    xferEdge;
  logic                    mcInEdge;
  logic                    mcCond;
  logic [31:0]             rv;
  logic [mcc_pkg::COLS-1:0] colWdata;
  logic [31:0]             colRead;

  // column n sits at msb-first bit n
  genvar gi;
  generate
    for (gi = 0; gi < mcc_pkg::COLS; gi++) begin : g_col
      assign colWdata[gi] = regWdata[mcc_pkg::COL_MSB-gi];
      assign colRead[mcc_pkg::COL_MSB-gi] = st.colMask[gi];
    end
  endgenerate
  assign colRead[mcc_pkg::COL_MSB-mcc_pkg::COLS:0] = '0;

  always_comb begin
    nxt        = st;
    rv         = 32'h0000_0000;
    nxt.rdata  = 32'h0000_0000;
    nxt.mcTrap = 1'b0;
    nxt.colDiscard = '0;
    nxt.bcastValid = 1'b0;
    nxt.localDone  = 1'b0;
    nxt.sync1 = {clkRatioPins, machineCheckN, transferErrN,
                 overTempPin, warmTempPin};
    nxt.sync2 = st.sync1;
    nxt.pinPrev = {st.sync2[mcc_pkg::SY_MC_IN],
                   st.sync2[mcc_pkg::SY_XFER_ERR]};
    // wait out the synchroniser before catching the straps
    if (!st.capDone) begin
      if (st.capCnt == mcc_pkg::SYNC_LAT) begin
        nxt.clkRatio = st.sync2[mcc_pkg::SY_CLK +: mcc_pkg::CB_CLK_W];
        nxt.capDone  = 1'b1;
      end else begin
        nxt.capCnt = st.capCnt + 2'h1;
      end
    end
    wrTrap  = regWr && (regAddr == mcc_pkg::ADDR_ERR_TRAP);
    wrCb    = regWr && (regAddr == mcc_pkg::ADDR_CACHE_BUS);
    wrCol   = regWr && (regAddr == mcc_pkg::ADDR_COL_MASK);
    colWrOk = wrCol && st.ctl.columnMaskWriteEn;
    xferEdge = st.pinPrev[0] && !st.sync2[mcc_pkg::SY_XFER_ERR];
    mcInEdge = st.pinPrev[1] && !st.sync2[mcc_pkg::SY_MC_IN];
    softRise = wrTrap && regWdata[mcc_pkg::ET_SOFT]
               && !st.trapEn.softTriggerCheck;
    if (wrTrap) begin
      // reset kind and temperature bits are not writable
      nxt.trapEn.fetchCheckEn    = regWdata[mcc_pkg::ET_FETCH];
      nxt.trapEn.tagStateCheckEn = regWdata[mcc_pkg::ET_TAG];
      nxt.trapEn.busStateCheckEn = regWdata[mcc_pkg::ET_BUSST];
      nxt.trapEn.parityCheckEn   = regWdata[mcc_pkg::ET_PARITY];
      nxt.trapEn.xlateCheckEn    = regWdata[mcc_pkg::ET_XLATE];
      nxt.trapEn.softTriggerCheck = regWdata[mcc_pkg::ET_SOFT];
    end
    if (wrCb) begin
      // clock ratio field is not writable
      nxt.ctl.coherenceBroadcastOff = regWdata[mcc_pkg::CB_COH];
      nxt.ctl.syncBroadcastOff  = regWdata[mcc_pkg::CB_SYNC];
      nxt.ctl.barrierBroadcastOff = regWdata[mcc_pkg::CB_BARR];
      nxt.ctl.tlbBroadcastOff   = regWdata[mcc_pkg::CB_TLB];
      nxt.strobeLevel           = regWdata[mcc_pkg::CB_STROBE];
      nxt.ctl.icacheEnable      = regWdata[mcc_pkg::CB_ICACHE];
      nxt.ctl.dcacheEnable      = regWdata[mcc_pkg::CB_DCACHE];
      nxt.ctl.l2Enable          = regWdata[mcc_pkg::CB_L2];
      nxt.ctl.instrPrefetchEn   = regWdata[mcc_pkg::CB_IPF];
      nxt.ctl.dataPrefetchEn    = regWdata[mcc_pkg::CB_DPF];
      nxt.ctl.columnMaskWriteEn = regWdata[mcc_pkg::CB_COLWR];
      nxt.ctl.tagValidWriteEn   = regWdata[mcc_pkg::CB_TAGWR];
      nxt.ctl.coherentFetchMode = regWdata[mcc_pkg::CB_COHFETCH];
    end
    if (colWrOk) begin
      nxt.colMask    = colWdata;
      nxt.colDiscard = colWdata & ~st.colMask;
    end
    mcCond = (err.fetchMultiHit && st.trapEn.fetchCheckEn)
          || (err.tagStateErr && st.trapEn.tagStateCheckEn)
          || (err.busStateErr && st.trapEn.busStateCheckEn)
          || (err.parityErr && st.trapEn.parityCheckEn)
          || (err.xlateMultiHit && st.trapEn.xlateCheckEn)
          || xferEdge || mcInEdge
          || softRise;
    case (st.mode)
      mcc_pkg::MCC_RUN: begin
        if (mcCond) begin
          if (machineCheckVectorEnable) begin
            nxt.mcTrap = 1'b1;
          end else begin
            nxt.mode = mcc_pkg::MCC_STOP;
          end
        end
      end
      mcc_pkg::MCC_STOP: begin
        nxt.mode = mcc_pkg::MCC_STOP;
      end
      default: begin
        nxt.mode = mcc_pkg::MCC_RUN;
      end
    endcase
    // breakpoint inverts the pin for the pulse length only
    nxt.strobePin = nxt.strobeLevel ^ bkptInvert;
    if (opValid) begin
      nxt.bcastKind = opKind;
      case (opKind)
        mcc_pkg::OP_CACHE: begin
          nxt.bcastValid = !st.ctl.coherenceBroadcastOff;
          nxt.localDone  = st.ctl.coherenceBroadcastOff;
        end
        mcc_pkg::OP_ZKILL: begin
          nxt.bcastValid = 1'b1;
        end
        mcc_pkg::OP_SYNC: begin
          nxt.bcastValid = !st.ctl.syncBroadcastOff;
          nxt.localDone  = st.ctl.syncBroadcastOff;
        end
        mcc_pkg::OP_BARRIER: begin
          nxt.bcastValid = !st.ctl.barrierBroadcastOff;
          nxt.localDone  = st.ctl.barrierBroadcastOff;
        end
        mcc_pkg::OP_TLBIE, mcc_pkg::OP_TLBSYNC: begin
          nxt.bcastValid = !st.ctl.tlbBroadcastOff;
          nxt.localDone  = st.ctl.tlbBroadcastOff;
        end
        default: begin
          nxt.localDone = 1'b1;
        end
      endcase
    end
    if (regRd) begin
      case (regAddr)
        mcc_pkg::ADDR_ERR_TRAP: begin
          rv[mcc_pkg::ET_WARM]  = st.sync2[mcc_pkg::SY_WARM];
          rv[mcc_pkg::ET_HOT]   = st.sync2[mcc_pkg::SY_HOT];
          rv[mcc_pkg::ET_RESET_KIND] = st.resetKind;
          rv[mcc_pkg::ET_FETCH]  = st.trapEn.fetchCheckEn;
          rv[mcc_pkg::ET_TAG]    = st.trapEn.tagStateCheckEn;
          rv[mcc_pkg::ET_BUSST]  = st.trapEn.busStateCheckEn;
          rv[mcc_pkg::ET_PARITY] = st.trapEn.parityCheckEn;
          rv[mcc_pkg::ET_XLATE]  = st.trapEn.xlateCheckEn;
          rv[mcc_pkg::ET_SOFT]   = st.trapEn.softTriggerCheck;
        end
        mcc_pkg::ADDR_CACHE_BUS: begin
          rv[mcc_pkg::CB_CLK_LSB +: mcc_pkg::CB_CLK_W] = st.clkRatio;
          rv[mcc_pkg::CB_COH]    = st.ctl.coherenceBroadcastOff;
          rv[mcc_pkg::CB_SYNC]   = st.ctl.syncBroadcastOff;
          rv[mcc_pkg::CB_BARR]   = st.ctl.barrierBroadcastOff;
          rv[mcc_pkg::CB_TLB]    = st.ctl.tlbBroadcastOff;
          rv[mcc_pkg::CB_STROBE] = st.strobeLevel;
          rv[mcc_pkg::CB_ICACHE] = st.ctl.icacheEnable;
          rv[mcc_pkg::CB_DCACHE] = st.ctl.dcacheEnable;
          rv[mcc_pkg::CB_L2]     = st.ctl.l2Enable;
          rv[mcc_pkg::CB_IPF]    = st.ctl.instrPrefetchEn;
          rv[mcc_pkg::CB_DPF]    = st.ctl.dataPrefetchEn;
          rv[mcc_pkg::CB_COLWR]  = st.ctl.columnMaskWriteEn;
          rv[mcc_pkg::CB_TAGWR]  = st.ctl.tagValidWriteEn;
          rv[mcc_pkg::CB_COHFETCH] = st.ctl.coherentFetchMode;
        end
        mcc_pkg::ADDR_COL_MASK: begin
          rv = colRead;
        end
        default: begin
          rv = 32'h0000_0000;
        end
      endcase
      nxt.rdata = rv;
    end
    // soft reset keeps straps and column mask
    if (softReset) begin
      nxt.resetKind   = mcc_pkg::SOFT_KIND;
      nxt.trapEn      = '0;
      nxt.ctl         = '0;
      nxt.strobeLevel = 1'b0;
      nxt.strobePin   = bkptInvert;
      nxt.mode        = mcc_pkg::MCC_RUN;
      nxt.mcTrap      = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st            <= '0;
      st.sync1      <= mcc_pkg::SYNC_RST;
      st.sync2      <= mcc_pkg::SYNC_RST;
      st.pinPrev    <= 2'h3;
      st.resetKind  <= mcc_pkg::HARD_KIND;
      st.colMask    <= mcc_pkg::COL_RST;
      st.mode       <= mcc_pkg::MCC_RUN;
      st.bcastKind  <= mcc_pkg::OP_CACHE;
    end else if (ce) begin
      st <= nxt;
    end
  end

  assign regRdata   = st.rdata;
  assign ctl        = st.ctl;
  assign strobePin  = st.strobePin;
  assign colDisable = st.colMask;
  assign colDiscard = st.colDiscard;
  assign mcTrap     = st.mcTrap;
  assign checkstop  = st.mode[1];
  assign bcastValid = st.bcastValid;
  assign bcastKind  = st.bcastKind;
  assign localDone  = st.localDone;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  property p_soft_kind;
    ce && softReset |=> !st.resetKind;
  endproperty
  a_soft_kind: assert property (p_soft_kind)
    else $error("reset kind not cleared by soft reset");

  property p_clk_hold;
    ce && st.capDone |=> st.clkRatio == $past(st.clkRatio);
  endproperty
  a_clk_hold: assert property (p_clk_hold)
    else $error("clock ratio changed after capture");

  property p_soft_trap;
    ce && softRise && machineCheckVectorEnable && !softReset
      && (st.mode == mcc_pkg::MCC_RUN)
      |=> mcTrap ##1 (!mcTrap || $past(mcCond) || !$past(ce));
  endproperty
  a_soft_trap: assert property (p_soft_trap)
    else $error("soft trigger gave no single check");

  property p_xfer_always;
    ce && xferEdge && !machineCheckVectorEnable && !softReset
      |=> checkstop;
  endproperty
  a_xfer_always: assert property (p_xfer_always)
    else $error("transfer error did not stop");

  property p_stop_hold;
    checkstop && !softReset |=> checkstop;
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("checkstop left without reset");

  property p_col_gate;
    ce && wrCol && !st.ctl.columnMaskWriteEn
      |=> colDisable == $past(colDisable);
  endproperty
  a_col_gate: assert property (p_col_gate)
    else $error("column mask written while locked");

  property p_discard;
    ce && colWrOk |=> colDiscard == (colDisable & ~$past(colDisable));
  endproperty
  a_discard: assert property (p_discard)
    else $error("discard pulse wrong");

  property p_strobe;
    ce |=> strobePin == (st.strobeLevel ^ $past(bkptInvert));
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("strobe pin mismatch");

  property p_zkill;
    ce && opValid && (opKind == mcc_pkg::OP_ZKILL) |=> bcastValid;
  endproperty
  a_zkill: assert property (p_zkill)
    else $error("zero kill not broadcast");

  property p_sync_local;
    ce && opValid && (opKind == mcc_pkg::OP_SYNC)
      && st.ctl.syncBroadcastOff |=> localDone && !bcastValid;
  endproperty
  a_sync_local: assert property (p_sync_local)
    else $error("suppressed sync not local");

  property p_mask_gate;
    ce && !softReset && err.parityErr && !st.trapEn.parityCheckEn
      && !xferEdge && !mcInEdge && !softRise && !err.fetchMultiHit
      && !err.tagStateErr && !err.busStateErr && !err.xlateMultiHit
      |=> !mcTrap;
  endproperty
  a_mask_gate: assert property (p_mask_gate)
    else $error("masked parity error trapped");

  property p_rd_once;
    ce && regRd |=> ##1 (regRdata == 32'h0000_0000) || $past(regRd)
      || !$past(ce);
  endproperty
  a_rd_once: assert property (p_rd_once)
    else $error("read data stood too long");

  property p_freeze;
    !ce |=> st == $past(st);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable low");

  property p_trap_vec;
    ce && mcCond && machineCheckVectorEnable && !softReset
      && (st.mode == mcc_pkg::MCC_RUN) |=> mcTrap && !checkstop;
  endproperty
  a_trap_vec: assert property (p_trap_vec)
    else $error("enabled check did not vector");

  property p_stop_enter;
    ce && mcCond && !machineCheckVectorEnable && !softReset
      && (st.mode == mcc_pkg::MCC_RUN) |=> checkstop && !mcTrap;
  endproperty
  a_stop_enter: assert property (p_stop_enter)
    else $error("unvectored check did not stop");

  property p_kind_ro;
    ce && wrTrap && !softReset |=> st.resetKind == $past(st.resetKind);
  endproperty
  a_kind_ro: assert property (p_kind_ro)
    else $error("reset kind changed by write");

  property p_col_rsvd;
    ce && regRd && (regAddr == mcc_pkg::ADDR_COL_MASK)
      |=> regRdata[mcc_pkg::COL_MSB-mcc_pkg::COLS:0] == '0;
  endproperty
  a_col_rsvd: assert property (p_col_rsvd)
    else $error("reserved column bits read nonzero");

  c_trap: cover property (ce && mcTrap);
  c_stop: cover property (ce && checkstop);
  c_discard: cover property (ce && (colDiscard != '0));
  c_bcast: cover property (ce && bcastValid ##1 localDone);
endmodule : mcc_control_regs

// ==== mcc_pkg.sv ====
package mcc_pkg;
  localparam logic [3:0] ADDR_ERR_TRAP  = 4'h0;
  localparam logic [3:0] ADDR_CACHE_BUS = 4'h4;
  localparam logic [3:0] ADDR_COL_MASK  = 4'h8;
  // bit n of the msb-first numbering sits at vector index 31-n
  localparam int ET_WARM       = 25;
  localparam int ET_HOT        = 24;
  localparam int ET_RESET_KIND = 23;
  localparam int ET_FETCH      = 22;
  localparam int ET_TAG        = 20;
  localparam int ET_BUSST      = 19;
  localparam int ET_PARITY     = 18;
  localparam int ET_XLATE      = 17;
  localparam int ET_SOFT       = 16;
  localparam int CB_CLK_LSB    = 16;
  localparam int CB_CLK_W      = 5;
  localparam int CB_COH        = 15;
  localparam int CB_SYNC       = 14;
  localparam int CB_BARR       = 13;
  localparam int CB_TLB        = 12;
  localparam int CB_STROBE     = 11;
  localparam int CB_ICACHE     = 10;
  localparam int CB_DCACHE     = 9;
  localparam int CB_L2         = 8;
  localparam int CB_IPF        = 4;
  localparam int CB_DPF        = 3;
  localparam int CB_COLWR      = 2;
  localparam int CB_TAGWR      = 1;
  localparam int CB_COHFETCH   = 0;
  localparam int COL_MSB       = 31;
  localparam int COLS          = 8;
  localparam int SY_WARM       = 0;
  localparam int SY_HOT        = 1;
  localparam int SY_XFER_ERR   = 2;
  localparam int SY_MC_IN      = 3;
  localparam int SY_CLK        = 4;
  localparam int SY_W          = 9;
  localparam logic [SY_W-1:0] SYNC_RST = 9'h00C;
  localparam logic [1:0] SYNC_LAT      = 2'h2;
  localparam logic       HARD_KIND     = 1'b1;
  localparam logic       SOFT_KIND     = 1'b0;
  localparam logic [7:0] COL_RST       = 8'h00;

  typedef enum logic [1:0] {
    MCC_RUN  = 2'b01,
    MCC_STOP = 2'b10
  } mcc_mode_e;

  typedef enum logic [2:0] {
    OP_CACHE   = 3'h0,
    OP_ZKILL   = 3'h1,
    OP_SYNC    = 3'h2,
    OP_BARRIER = 3'h3,
    OP_TLBIE   = 3'h4,
    OP_TLBSYNC = 3'h5
  } mcc_op_e;

  typedef struct packed {
    logic coherenceBroadcastOff;
    logic syncBroadcastOff;
    logic barrierBroadcastOff;
    logic tlbBroadcastOff;
    logic icacheEnable;
    logic dcacheEnable;
    logic l2Enable;
    logic instrPrefetchEn;
    logic dataPrefetchEn;
    logic columnMaskWriteEn;
    logic tagValidWriteEn;
    logic coherentFetchMode;
  } mcc_ctl_s;

  typedef struct packed {
    logic fetchMultiHit;
    logic tagStateErr;
    logic busStateErr;
    logic parityErr;
    logic xlateMultiHit;
  } mcc_err_s;

  typedef struct packed {
    logic fetchCheckEn;
    logic tagStateCheckEn;
    logic busStateCheckEn;
    logic parityCheckEn;
    logic xlateCheckEn;
    logic softTriggerCheck;
  } mcc_trap_en_s;

  typedef struct packed {
    logic [SY_W-1:0]     sync1;
    logic [SY_W-1:0]     sync2;
    logic [1:0]          pinPrev;
    logic [1:0]          capCnt;
    logic                capDone;
    logic [CB_CLK_W-1:0] clkRatio;
    logic                resetKind;
    mcc_trap_en_s        trapEn;
    mcc_ctl_s            ctl;
    logic                strobeLevel;
    logic [COLS-1:0]     colMask;
    logic [COLS-1:0]     colDiscard;
    logic                strobePin;
    logic [31:0]         rdata;
    logic                mcTrap;
    mcc_mode_e           mode;
    logic                bcastValid;
    mcc_op_e             bcastKind;
    logic                localDone;
  } mcc_state_s;
endpackage : mcc_pkg

// ==== test_machine_check_and_cache_control.sv ====
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module test_machine_check_and_cache_control;
  logic                 core_clk = 1'b0;
  logic                 resetn = 1'b0;
  logic                 ce = 1'b1;
  logic [3:0]           regAddr = 4'h0;
  logic [31:0]          regWdata = 32'h0;
  logic                 regWr = 1'b0;
  logic                 regRd = 1'b0;
  logic [31:0]          regRdata;
  logic                 softReset = 1'b0;
  logic                 warmTempPin = 1'b0;
  logic                 overTempPin = 1'b0;
  logic [4:0]           clkRatioPins = 5'h15;
  logic                 transferErrN = 1'b1;
  logic                 machineCheckN = 1'b1;
  mcc_pkg::mcc_err_s    err = '0;
  logic                 machineCheckVectorEnable = 1'b1;
  logic                 bkptInvert = 1'b0;
  logic                 opValid = 1'b0;
  mcc_pkg::mcc_op_e     opKind = mcc_pkg::OP_CACHE;
  mcc_pkg::mcc_ctl_s    ctl;
  logic                 strobePin;
  logic [7:0]           colDisable;
  logic [7:0]           colDiscard;
  logic                 mcTrap;
  logic                 checkstop;
  logic                 bcastValid;
  mcc_pkg::mcc_op_e     bcastKind;
  logic                 localDone;
  int                   mismatches = 0;
  int                   comparisons = 0;
  logic [31:0]          d;
  int                   c;

  always #5 core_clk = ~core_clk;

  mcc_control_regs i_mcc_control_regs (.core_clk(core_clk), .resetn(resetn),
    .ce(ce), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .softReset(softReset),
    .warmTempPin(warmTempPin), .overTempPin(overTempPin),
    .clkRatioPins(clkRatioPins), .transferErrN(transferErrN),
    .machineCheckN(machineCheckN), .err(err),
    .machineCheckVectorEnable(machineCheckVectorEnable),
    .bkptInvert(bkptInvert), .opValid(opValid), .opKind(opKind), .ctl(ctl),
    .strobePin(strobePin), .colDisable(colDisable), .colDiscard(colDiscard),
    .mcTrap(mcTrap), .checkstop(checkstop), .bcastValid(bcastValid),
    .bcastKind(bcastKind), .localDone(localDone));

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge core_clk);
    regWr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask : rd

  // counts trap pulses seen over n cycles
  task automatic traps_in(input int n, output int cnt);
    cnt = 0;
    repeat (n) begin
      @(posedge core_clk);
      #1 if (mcTrap === 1'b1) cnt++;
    end
  endtask : traps_in

  task automatic pulse_err(input logic [4:0] v);
    @(posedge core_clk);
    err <= v;
    @(posedge core_clk);
    err <= '0;
    #1;
  endtask : pulse_err

  task automatic hard_reset;
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask : hard_reset

  task automatic t_reset;
    rd(mcc_pkg::ADDR_ERR_TRAP, d);
    `CHK(d, 32'h0080_0000)
    rd(mcc_pkg::ADDR_CACHE_BUS, d);
    `CHK(d, 32'h0015_0000)
    rd(mcc_pkg::ADDR_COL_MASK, d);
    `CHK(d, 32'h0)
    rd(4'hC, d);
    `CHK(d, 32'h0)
    `CHK({mcTrap, checkstop, colDisable}, 10'h0)
  endtask : t_reset

  task automatic t_soft_trigger;
    wr(mcc_pkg::ADDR_ERR_TRAP, 32'hFFFF_FFFF);
    `CHK(mcTrap, 1'b1)
    traps_in(1, c);
    `CHK(c, 0)
    rd(mcc_pkg::ADDR_ERR_TRAP, d);
    `CHK(d, 32'h00DF_0000)
    wr(mcc_pkg::ADDR_ERR_TRAP, 32'hFFFF_FFFF);
    traps_in(3, c);
    `CHK(c, 0)
    wr(mcc_pkg::ADDR_ERR_TRAP, 32'h0);
    wr(mcc_pkg::ADDR_ERR_TRAP, 32'h0001_0000);
    `CHK(mcTrap, 1'b1)
  endtask : t_soft_trigger

  task automatic t_errors;
    int enIdx[5] = '{17, 18, 19, 20, 22};
    for (int i = 0; i < 5; i++) begin
      wr(mcc_pkg::ADDR_ERR_TRAP, 32'h1 << enIdx[i]);
      pulse_err(5'h1F ^ (5'h1 << i));
      `CHK(mcTrap, 1'b0)
      pulse_err(5'h1 << i);
      `CHK(mcTrap, 1'b1)
    end
    wr(mcc_pkg::ADDR_ERR_TRAP, 32'h0);
    pulse_err(5'h02);
    `CHK(mcTrap, 1'b0)
    @(posedge core_clk);
    transferErrN <= 1'b0;
    traps_in(10, c);
    `CHK(c, 1)
    @(posedge core_clk);
    transferErrN <= 1'b1;
    machineCheckN <= 1'b0;
    traps_in(10, c);
    `CHK(c, 1)
    @(posedge core_clk);
    machineCheckN <= 1'b1;
    traps_in(6, c);
    `CHK(c, 0)
  endtask : t_errors

  task automatic t_control;
    logic loc;
    wr(mcc_pkg::ADDR_CACHE_BUS, 32'hFFFF_FFFF);
    `CHK(ctl, 12'hFFF)
    rd(mcc_pkg::ADDR_CACHE_BUS, d);
    `CHK(d, 32'h0015_FF1F)
    `CHK(strobePin, 1'b1)
    @(posedge core_clk);
    bkptInvert <= 1'b1;
    @(posedge core_clk);
    bkptInvert <= 1'b0;
    #1 `CHK(strobePin, 1'b0)
    @(posedge core_clk);
    #1 `CHK(strobePin, 1'b1)
    for (int b = 0; b < 5; b++) begin
      wr(mcc_pkg::ADDR_CACHE_BUS, (b < 4) ? (32'h8004 >> b) | 32'h4 : 32'h4);
      for (int k = 0; k < 8; k++) begin
        loc = (b == 0 && k == 0) || (b == 1 && k == 2) || k >= 6 ||
              (b == 2 && k == 3) || (b == 3 && k >= 4);
        @(posedge core_clk);
        opValid <= 1'b1;
        opKind <= mcc_pkg::mcc_op_e'(k);
        @(posedge core_clk);
        opValid <= 1'b0;
        #1 `CHK({bcastValid, localDone}, {~loc, loc})
        if (!loc) `CHK(bcastKind, mcc_pkg::mcc_op_e'(k))
      end
    end
  endtask : t_control

  task automatic t_columns;
    wr(mcc_pkg::ADDR_CACHE_BUS, 32'h0);
    wr(mcc_pkg::ADDR_COL_MASK, 32'hFF00_0000);
    `CHK(colDisable, 8'h00)
    wr(mcc_pkg::ADDR_CACHE_BUS, 32'h4);
    wr(mcc_pkg::ADDR_COL_MASK, 32'h88FF_FFFF);
    `CHK({colDisable, colDiscard}, 16'h1111)
    wr(mcc_pkg::ADDR_COL_MASK, 32'hC800_0000);
    `CHK({colDisable, colDiscard}, 16'h1302)
    @(posedge core_clk);
    #1 `CHK(colDiscard, 8'h00)
    @(posedge core_clk);
    ce <= 1'b0;
    wr(mcc_pkg::ADDR_COL_MASK, 32'hFF00_0000);
    `CHK(colDisable, 8'h13)
    @(posedge core_clk);
    ce <= 1'b1;
    rd(mcc_pkg::ADDR_COL_MASK, d);
    `CHK(d, 32'hC800_0000)
  endtask : t_columns

  task automatic t_temperature;
    @(posedge core_clk);
    warmTempPin <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(mcc_pkg::ADDR_ERR_TRAP, d);
    `CHK(d[25:24], 2'b10)
    @(posedge core_clk);
    warmTempPin <= 1'b0;
    overTempPin <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(mcc_pkg::ADDR_ERR_TRAP, d);
    `CHK(d[25:24], 2'b01)
    @(posedge core_clk);
    overTempPin <= 1'b0;
    repeat (4) @(posedge core_clk);
    wr(mcc_pkg::ADDR_ERR_TRAP, 32'h0300_0000);
    rd(mcc_pkg::ADDR_ERR_TRAP, d);
    `CHK(d, 32'h0080_0000)
  endtask : t_temperature

  task automatic t_checkstop_and_resets;
    @(posedge core_clk);
    machineCheckVectorEnable <= 1'b0;
    wr(mcc_pkg::ADDR_ERR_TRAP, 32'h0040_0000);
    pulse_err(5'h10);
    `CHK({checkstop, mcTrap}, 2'b10)
    @(posedge core_clk);
    machineCheckVectorEnable <= 1'b1;
    pulse_err(5'h10);
    `CHK({checkstop, mcTrap}, 2'b10)
    @(posedge core_clk);
    softReset <= 1'b1;
    @(posedge core_clk);
    softReset <= 1'b0;
    #1 `CHK({checkstop, ctl}, 13'h0)
    rd(mcc_pkg::ADDR_ERR_TRAP, d);
    `CHK(d, 32'h0)
    rd(mcc_pkg::ADDR_COL_MASK, d);
    `CHK(d, 32'hC800_0000)
    @(posedge core_clk);
    machineCheckVectorEnable <= 1'b0;
    transferErrN <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1 `CHK(checkstop, 1'b1)
    @(posedge core_clk);
    machineCheckVectorEnable <= 1'b1;
    transferErrN <= 1'b1;
    hard_reset();
    rd(mcc_pkg::ADDR_ERR_TRAP, d);
    `CHK(d, 32'h0080_0000)
    `CHK(colDisable, 8'h00)
  endtask : t_checkstop_and_resets

  initial begin
    #100us;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_reset();
    t_soft_trigger();
    t_errors();
    t_control();
    t_columns();
    t_temperature();
    t_checkstop_and_resets();
    tally_and_finish();
  end
endmodule : test_machine_check_and_cache_control
